// [hw/hsps_top.v]
// Hall or sensorless drive select and motor port routing, AXI4-Lite
// Function
// - Sensorless mode measures the phase whose Hall pin is driven high.
// - Sensorless mode disables speed output, commutation and lock detection.
// - Writing trigger 0 keeps the current port assignment.
// - Writing trigger 1 reconnects signals per the U, V, W selects.
// - Trigger bit returns to 0 by itself after taking effect.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "hsps_consts.vh"

module hsps_top (
  input wire clk,
  input wire reset,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [`HSPS_AW-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [`HSPS_AW-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire hallInputU,
  input wire hallInputV,
  input wire hallInputW,
  input wire speedPulseIn,
  input wire commutationIn,
  input wire lockDetectIn,
  input wire [2:0] phaseDrive,
  output wire hallSupplySwitchN,
  output wire sensorlessMode,
  output wire speedPulseOutput,
  output wire commutationEn,
  output wire lockDetect,
  output wire [2:0] bemfPhaseSel,
  output wire [`HSPS_PORTS-1:0] motorPortOut
);

  // Write channel holding registers
  reg awHeld_q;
  reg [`HSPS_AW-1:0] awAddr_q;
  reg wHeld_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  wire doWrite;
  wire [31:0] wrMerged;
  reg [31:0] wrOld;
  reg wrMapped;

  // Software visible state
  reg [1:0] ctrl_q;
  reg [8:0] sel_q;
  reg routeTrig_q;
  reg multiErr_q;
  reg modeErr_q;
  reg [7:0] applyCount_q;

  // Read side
  reg [31:0] rdWord;
  reg rdMapped;

  wire [8:0] appliedSel;
  wire [2:0] bemfPhase;
  wire multiSelect;
  wire [2:0] hallVec;
  wire ctrlWrite;
  wire selWrite;
  wire statusWrite;
  wire trigWrite;
  wire goingSensorless;

  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0] strb;
    integer i;
    begin
      mergeBytes = oldWord;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
        end
      end
    end
  endfunction

  assign hallVec = {hallInputW, hallInputV, hallInputU};

  // Address and data may arrive in either order; one write at a time
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always @(posedge clk) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      awAddr_q <= {`HSPS_AW{1'b0}};
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
    end
  end

  // Present value of the addressed word, for byte-lane merging
  always @* begin
    wrOld = 32'h0000_0000;
    wrMapped = 1'b1;
    case (awAddr_q)
      `HSPS_ADDR_CTRL: wrOld = {30'h0000_0000, ctrl_q};
      `HSPS_ADDR_SEL: begin
        wrOld = {21'h00_0000, sel_q[8:6], 1'b0, sel_q[5:3], 1'b0,
          sel_q[2:0]};
      end
      `HSPS_ADDR_STATUS: wrOld = 32'h0000_0000;
      default: wrMapped = 1'b0;
    endcase
  end

  assign wrMerged = mergeBytes(wrOld, wData_q, wStrb_q);
  assign ctrlWrite = doWrite && (awAddr_q == `HSPS_ADDR_CTRL);
  assign selWrite = doWrite && (awAddr_q == `HSPS_ADDR_SEL);
  assign statusWrite = doWrite && (awAddr_q == `HSPS_ADDR_STATUS);
  // Lane 1 must be enabled for the trigger bit to count
  assign trigWrite = ctrlWrite && wStrb_q[1] &&
    wData_q[`HSPS_CTRL_TRIG];
  assign goingSensorless = ctrlWrite && !ctrl_q[`HSPS_CTRL_MODE] &&
    wrMerged[`HSPS_CTRL_MODE];

  always @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HSPS_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? `HSPS_RESP_OKAY : `HSPS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `HSPS_CTRL_RST;
      sel_q <= `HSPS_SEL_RST;
    end else begin
      if (ctrlWrite) begin
        ctrl_q <= wrMerged[1:0];
      end
      if (selWrite) begin
        sel_q <= {wrMerged[`HSPS_SEL_W_LSB +: `HSPS_SEL_W],
          wrMerged[`HSPS_SEL_V_LSB +: `HSPS_SEL_W],
          wrMerged[`HSPS_SEL_U_LSB +: `HSPS_SEL_W]};
      end
    end
  end

  // Trigger is never stored; a single pulse, then back to 0
  always @(posedge clk) begin
    if (reset) begin
      routeTrig_q <= 1'b0;
    end else begin
      routeTrig_q <= trigWrite;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      applyCount_q <= 8'h00;
    end else if (routeTrig_q) begin
      applyCount_q <= applyCount_q + 8'h01;
    end
  end

  // Sticky faults; a new event beats a clear in the same cycle
  always @(posedge clk) begin
    if (reset) begin
      multiErr_q <= 1'b0;
      modeErr_q <= 1'b0;
    end else begin
      multiErr_q <= multiSelect || (multiErr_q && !(statusWrite &&
        wStrb_q[1] && wData_q[`HSPS_ST_MULTI]));
      // Switch must be 0 and Hall pins low before entering sensorless
      modeErr_q <= (goingSensorless &&
        (ctrl_q[`HSPS_CTRL_SUPPLY] || hallVec != 3'h0)) ||
        (modeErr_q && !(statusWrite && wStrb_q[1] &&
        wData_q[`HSPS_ST_MODEERR]));
    end
  end

  // Read channel: one read at a time, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rdWord = 32'h0000_0000;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      `HSPS_ADDR_CTRL: rdWord = {30'h0000_0000, ctrl_q};
      `HSPS_ADDR_SEL: begin
        rdWord = {21'h00_0000, sel_q[8:6], 1'b0, sel_q[5:3], 1'b0,
          sel_q[2:0]};
      end
      `HSPS_ADDR_STATUS: begin
        rdWord[`HSPS_ST_HALL_LSB +: 3] = hallVec;
        rdWord[`HSPS_ST_BEMF_LSB +: 3] = bemfPhase;
        rdWord[`HSPS_ST_MULTI] = multiErr_q;
        rdWord[`HSPS_ST_MODEERR] = modeErr_q;
        rdWord[`HSPS_ST_SENSLESS] = ctrl_q[`HSPS_CTRL_MODE];
      end
      `HSPS_ADDR_ROUTE: begin
        rdWord = {21'h00_0000, appliedSel[8:6], 1'b0, appliedSel[5:3],
          1'b0, appliedSel[2:0]};
      end
      `HSPS_ADDR_COUNT: rdWord = {24'h00_0000, applyCount_q};
      default: rdMapped = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HSPS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdMapped ? `HSPS_RESP_OKAY : `HSPS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  hsps_port_route uRoute (
    .clk(clk),
    .reset(reset),
    .applyPulse(routeTrig_q),
    .selectWord(sel_q),
    .phaseSig(phaseDrive),
    .appliedSel_q(appliedSel),
    .portOut_q(motorPortOut)
  );

  hsps_mode_gate uGate (
    .clk(clk),
    .reset(reset),
    .sensorless(ctrl_q[`HSPS_CTRL_MODE]),
    .hallInputU(hallInputU),
    .hallInputV(hallInputV),
    .hallInputW(hallInputW),
    .speedPulseIn(speedPulseIn),
    .commutationIn(commutationIn),
    .lockDetectIn(lockDetectIn),
    .speedPulseOutput_q(speedPulseOutput),
    .commutationEn_q(commutationEn),
    .lockDetect_q(lockDetect),
    .bemfPhase_q(bemfPhase),
    .multiSelect(multiSelect)
  );

  assign bemfPhaseSel = bemfPhase;
  assign hallSupplySwitchN = ctrl_q[`HSPS_CTRL_SUPPLY];
  assign sensorlessMode = ctrl_q[`HSPS_CTRL_MODE];

endmodule

// [hw/hsps_consts.vh]
// Register map, field positions and reset values of the port select block
`ifndef HSPS_CONSTS_VH
`define HSPS_CONSTS_VH

`define HSPS_AW 5
`define HSPS_ADDR_CTRL 5'h00
`define HSPS_ADDR_SEL 5'h04
`define HSPS_ADDR_STATUS 5'h08
`define HSPS_ADDR_ROUTE 5'h0C
`define HSPS_ADDR_COUNT 5'h10

`define HSPS_CTRL_MODE 0
`define HSPS_CTRL_SUPPLY 1
`define HSPS_CTRL_TRIG 8
`define HSPS_CTRL_RST 2'h2

`define HSPS_SEL_U_LSB 0
`define HSPS_SEL_V_LSB 4
`define HSPS_SEL_W_LSB 8
`define HSPS_SEL_W 3
`define HSPS_SEL_RST 9'h088

`define HSPS_ST_HALL_LSB 0
`define HSPS_ST_BEMF_LSB 4
`define HSPS_ST_MULTI 8
`define HSPS_ST_MODEERR 9
`define HSPS_ST_SENSLESS 10

`define HSPS_PORTS 8
`define HSPS_RESP_OKAY 2'h0
`define HSPS_RESP_SLVERR 2'h2

`endif

// [hw/hsps_port_route.v]
// Routes the three phase drive signals onto the output ports
`timescale 1ns/100ps
`include "hsps_consts.vh"

module hsps_port_route (
  input wire clk,
  input wire reset,
  input wire applyPulse,
  input wire [8:0] selectWord,
  input wire [2:0] phaseSig,
  output reg [8:0] appliedSel_q,
  output reg [`HSPS_PORTS-1:0] portOut_q
);

  genvar p;

  // New assignment only on the one-cycle trigger; else held
  always @(posedge clk) begin
    if (reset) begin
      appliedSel_q <= `HSPS_SEL_RST;
    end else if (applyPulse) begin
      appliedSel_q <= selectWord;
    end
  end

  // Each port carries whichever phases currently point at it
  generate
    for (p = 0; p < `HSPS_PORTS; p = p + 1) begin : gPort
      // A genvar cannot be part-selected; take a sized copy
      localparam [2:0] PORT_IDX = p;
      always @(posedge clk) begin
        if (reset) begin
          portOut_q[p] <= 1'b0;
        end else begin
          portOut_q[p] <=
            (phaseSig[0] && appliedSel_q[2:0] == PORT_IDX) ||
            (phaseSig[1] && appliedSel_q[5:3] == PORT_IDX) ||
            (phaseSig[2] && appliedSel_q[8:6] == PORT_IDX);
        end
      end
    end
  endgenerate

endmodule

// [hw/hsps_mode_gate.v]
// Sensorless gating of speed, commutation and lock, and phase pick
`timescale 1ns/100ps

module hsps_mode_gate (
  input wire clk,
  input wire reset,
  input wire sensorless,
  input wire hallInputU,
  input wire hallInputV,
  input wire hallInputW,
  input wire speedPulseIn,
  input wire commutationIn,
  input wire lockDetectIn,
  output reg speedPulseOutput_q,
  output reg commutationEn_q,
  output reg lockDetect_q,
  output reg [2:0] bemfPhase_q,
  output wire multiSelect
);

  wire [2:0] hallVec;
  wire oneHigh;

  assign hallVec = {hallInputW, hallInputV, hallInputU};
  assign oneHigh = (hallVec == 3'h1) || (hallVec == 3'h2) ||
    (hallVec == 3'h4);
  // Several phases at once is illegal; flagged, never measured
  assign multiSelect = sensorless && !oneHigh && (hallVec != 3'h0);

  always @(posedge clk) begin
    if (reset) begin
      speedPulseOutput_q <= 1'b0;
      commutationEn_q <= 1'b0;
      lockDetect_q <= 1'b0;
      bemfPhase_q <= 3'h0;
    end else begin
      speedPulseOutput_q <= !sensorless && speedPulseIn;
      commutationEn_q <= !sensorless && commutationIn;
      lockDetect_q <= !sensorless && lockDetectIn;
      bemfPhase_q <= (sensorless && oneHigh) ? hallVec : 3'h0;
    end
  end

endmodule

// [verification/hsps_hall_ctrl.sv]
// Controller model driving the Hall pins
`timescale 1ns/100ps
module hsps_hall_ctrl (
  input wire clk,
  input wire [1:0] pick,
  output reg [2:0] hall
);
  // Code 0 keeps every pin low
  initial hall = 3'h0;
  always @(posedge clk)
    hall <= (pick == 2'h0) ? 3'h0 : 3'(3'h1 << (pick - 2'h1));
endmodule

// [verification/hsps_top_properties.sv]
// Checker for the port select block
`timescale 1ns/100ps
`include "hsps_consts.vh"
module hsps_checker (
  input wire clk,
  input wire reset,
  input wire s_axi_wvalid,
  input wire hallInputU,
  input wire hallInputV,
  input wire hallInputW,
  input wire speedPulseIn,
  input wire commutationIn,
  input wire lockDetectIn,
  input wire [2:0] phaseDrive,
  input wire sensorlessMode,
  input wire speedPulseOutput,
  input wire commutationEn,
  input wire lockDetect,
  input wire [2:0] bemfPhaseSel,
  input wire [`HSPS_PORTS-1:0] motorPortOut
);
  wire [2:0] hall = {hallInputW, hallInputV, hallInputU};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Six quiet cycles cover the whole trigger pipeline
  sequence s_quiet;
    !s_axi_wvalid [*6] ##0 $stable(phaseDrive);
  endsequence
  property p_gated;
    sensorlessMode |=> !speedPulseOutput && !commutationEn && !lockDetect;
  endproperty
  a_gated: assert property (p_gated)
    else $error("Functions not gated");
  property p_follow;
    !sensorlessMode |=> {speedPulseOutput, commutationEn, lockDetect} ==
      $past({speedPulseIn, commutationIn, lockDetectIn});
  endproperty
  a_follow: assert property (p_follow)
    else $error("Functions not passed");
  property p_phase;
    sensorlessMode && $onehot(hall) |=> bemfPhaseSel == $past(hall);
  endproperty
  a_phase: assert property (p_phase)
    else $error("Wrong phase");
  property p_nophase;
    !(sensorlessMode && $onehot(hall)) |=> bemfPhaseSel == 3'h0;
  endproperty
  a_nophase: assert property (p_nophase)
    else $error("Phase without pick");
  property p_hold;
    s_quiet |=> $stable(motorPortOut);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Ports moved");
  property p_zero;
    phaseDrive == 3'h0 |=> motorPortOut == '0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("Ports without drive");
endmodule
bind hsps_top hsps_checker hsps_checker_inst (.clk(clk), .reset(reset),
  .s_axi_wvalid(s_axi_wvalid), .hallInputU(hallInputU),
  .hallInputV(hallInputV), .hallInputW(hallInputW),
  .speedPulseIn(speedPulseIn), .commutationIn(commutationIn),
  .lockDetectIn(lockDetectIn), .phaseDrive(phaseDrive),
  .sensorlessMode(sensorlessMode), .speedPulseOutput(speedPulseOutput),
  .commutationEn(commutationEn), .lockDetect(lockDetect),
  .bemfPhaseSel(bemfPhaseSel), .motorPortOut(motorPortOut));

// [verification/hsps_top_bench.sv]
// Self-checking bench for the port select block
`timescale 1ns/100ps
`include "hsps_consts.vh"
module hsps_top_bench;
  logic clk = 0, reset = 1, awv = 0, wv = 0, arv = 0, bRdy = 0, rRdy = 0;
  logic [4:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rd, q, sel, cur, cnt;
  logic awr, wr, arr, bv, rv, spo, cen, lkd, hsn, smode;
  logic [1:0] bresp, pick = 0;
  logic [2:0] hall, bemf, fnIn = 0, drive = 0;
  logic [7:0] ports;
  int n_fail = 0, checks_done = 0, p;
  hsps_top hsps_top_inst (.clk(clk), .reset(reset),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(aw),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
    .s_axi_bready(bRdy), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ar), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rRdy), .s_axi_rdata(rd),
    .s_axi_rresp(), .hallInputU(hall[0]), .hallInputV(hall[1]),
    .hallInputW(hall[2]), .speedPulseIn(fnIn[0]), .commutationIn(fnIn[1]),
    .lockDetectIn(fnIn[2]), .phaseDrive(drive), .hallSupplySwitchN(hsn),
    .sensorlessMode(smode), .speedPulseOutput(spo), .commutationEn(cen),
    .lockDetect(lkd), .bemfPhaseSel(bemf), .motorPortOut(ports));
  hsps_hall_ctrl hsps_hall_ctrl_inst (.clk(clk), .pick(pick), .hall(hall));
  initial forever #4 clk = ~clk;
  always @(posedge clk) fnIn <= 3'($urandom);
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Ready is read at the falling edge, where it equals what the rise samples
  task automatic bus(input bit w, input [4:0] a, input [31:0] d,
                     output [31:0] r);
    bit ta, tw, tr, dn;
    int n;
    aw <= a; ar <= a; wd <= d; awv <= w; wv <= w; arv <= !w;
    bRdy <= w; rRdy <= !w; n = 0; dn = 0;
    while (!dn) begin
      @(negedge clk);
      ta = awv && awr; tw = wv && wr; tr = arv && arr;
      if (bv && bRdy) begin
        r = {30'h0, bresp}; dn = 1;
      end
      if (rv && rRdy) begin
        r = rd; dn = 1;
      end
      if (++n > 60) begin
        n_fail++; dn = 1;
      end
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tr) arv <= 0;
      if (dn) begin
        bRdy <= 0; rRdy <= 0;
      end
    end
    @(posedge clk);
  endtask
  function automatic [7:0] pmap(input [31:0] s, input [2:0] d);
    pmap = 8'h00;
    pmap[s[2:0]] |= d[0];
    pmap[s[6:4]] |= d[1];
    pmap[s[10:8]] |= d[2];
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end
  initial begin
    void'($urandom(32'hdeef_99fe));
    repeat (3) @(posedge clk);
    reset <= 0;
    cur = 32'h0000_0210;
    bus(0, `HSPS_ADDR_CTRL, 0, q); chk(q, 32'h0000_0002);
    bus(0, `HSPS_ADDR_ROUTE, 0, q); chk(q, cur);
    bus(0, 5'h14, 0, q); chk(q, 0);
    bus(1, 5'h14, 0, q); chk(q, `HSPS_RESP_SLVERR);
    bus(0, `HSPS_ADDR_COUNT, 0, cnt);
    repeat (8) begin
      sel = $urandom & 32'h0000_0777;
      drive <= 3'($urandom);
      bus(1, `HSPS_ADDR_SEL, sel, q);
      bus(1, `HSPS_ADDR_CTRL, 32'h0000_0002, q);
      @(negedge clk); chk(ports, pmap(cur, drive));
      @(posedge clk);
      bus(1, `HSPS_ADDR_CTRL, 32'h0000_0102, q);
      repeat (2) @(posedge clk);
      cur = sel;
      @(negedge clk); chk(ports, pmap(cur, drive));
      @(posedge clk);
      bus(0, `HSPS_ADDR_CTRL, 0, q); chk(q, 32'h0000_0002);
      bus(0, `HSPS_ADDR_ROUTE, 0, q); chk(q, sel);
      bus(0, `HSPS_ADDR_COUNT, 0, q); chk(q[7:0], cnt[7:0] + 8'h01);
      cnt = q;
    end
    bus(1, `HSPS_ADDR_CTRL, 0, q);
    bus(1, `HSPS_ADDR_CTRL, 32'h0000_0001, q);
    bus(0, `HSPS_ADDR_STATUS, 0, q); chk(q[10:8], 3'h4);
    for (p = 1; p < 4; p++) begin
      pick <= 2'(p);
      repeat (4) @(posedge clk);
      @(negedge clk); chk({spo, cen, lkd, bemf}, 6'(1 << (p - 1)));
      @(posedge clk);
    end
    pick <= 0;
    bus(1, `HSPS_ADDR_CTRL, 32'h0000_0002, q);
    chk({hsn, smode}, 2'h2);
    // Entering sensorless with the supply switch still 1 is a fault
    bus(1, `HSPS_ADDR_CTRL, 32'h0000_0003, q);
    bus(0, `HSPS_ADDR_STATUS, 0, q); chk(q[10:8], 3'h6);
    chk({hsn, smode}, 2'h3);
    bus(1, `HSPS_ADDR_STATUS, 32'h0000_0200, q);
    bus(0, `HSPS_ADDR_STATUS, 0, q); chk(q[10:8], 3'h4);
    bus(1, `HSPS_ADDR_CTRL, 32'h0000_0002, q);
    repeat (10) @(posedge clk);
    finish_test;
  end
endmodule
